// ### hdl/ebac_ctrl.sv
// Indirect single-byte nvm access controller with APB register port
//
// Local design decisions: register access over APB and the register offsets.
module ebac_ctrl
  import ebac_pkg::*;
#(
  parameter int WRITE_TICKS = DEF_WRITE_TICKS, // Timer ticks per write cycle
  parameter int READ_CYCLES = DEF_READ_CYCLES  // System cycles per read, at least 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_timer_tick,
  input wire logic stack_full,
  input wire logic irq_serviced,
  output logic irq_vector_req,
  output logic busy
);

  // Counter is sized for whichever operation counts further
  localparam int CNT_MAX = (WRITE_TICKS > READ_CYCLES) ? WRITE_TICKS : READ_CYCLES;
  localparam int CW = $clog2(CNT_MAX + 1);
  localparam logic [CW-1:0] WRITE_LAST = CW'(WRITE_TICKS - 1);
  localparam logic [CW-1:0] READ_LAST = CW'(READ_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  // Zero-extend a byte to a bus word
  function automatic logic [31:0] word_of(input logic [7:0] b);
    word_of = {24'h000000, b};
  endfunction

  // True when the bus address selects the given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Software-visible registers
  logic [LOC_W-1:0] nvm_location; // Byte index, six bits
  logic [7:0] nvm_byte; // Data in and out
  logic [7:0] bank_select; // Bank pointer
  logic [7:0] indirect_pointer_one; // Memory pointer for the indirect port
  ebac_ctrl_s nvm_control; // Permits and go bits
  ebac_irq_s irq_ctrl; // Enables and request flag

  // Sequencer
  ebac_state_e state;
  logic [CW-1:0] cnt; // Tick or cycle count within an operation
  logic [LOC_W-1:0] op_addr; // Location captured at start
  logic [7:0] op_data; // Byte captured at start

  // Bus decode
  logic wr_acc; // Write takes effect in access phase
  logic rd_setup; // Read data is prepared in setup phase
  logic low_lane; // Byte lane 0 enabled
  logic ctrl_open; // Indirect port currently reaches the control register
  logic mapped; // Address is one of ours

  // Derived events
  logic tick_rise; // Synchronised timer tick
  logic prog_req; // Legal write start request
  logic fetch_req; // Legal read start request
  logic write_done; // Last tick of a write
  logic read_done; // Last cycle of a read
  logic mem_wr;
  logic mem_rd;
  logic [7:0] mem_rdata;

  // APB decode; access phase always completes at once
  assign pready = psel && penable;
  assign wr_acc = psel && penable && pwrite && low_lane;
  assign rd_setup = psel && !penable && !pwrite;
  assign low_lane = pstrb[0];
  assign ctrl_open = (bank_select == CTRL_BANK) &&
                     (indirect_pointer_one == CTRL_POINTER); // see R17
  assign mapped = hit(paddr, OFF_LOCATION) || hit(paddr, OFF_BYTE) || hit(paddr, OFF_BANK) ||
                  hit(paddr, OFF_POINTER) || hit(paddr, OFF_INDIRECT) || hit(paddr, OFF_IRQ);
  assign busy = (state != ST_IDLE);

  // Write start needs the permit already stored, an idle engine, and no
  // conflicting go bit; a write of all four bits starts nothing.
  // Requests are only ever raised while the engine is idle.
  always_comb begin
    prog_req = 1'b0;
    fetch_req = 1'b0;
    if (wr_acc && hit(paddr, OFF_INDIRECT) && ctrl_open && (state == ST_IDLE)) begin
      if (!(pwdata[CTL_PROGRAM_GO] && pwdata[CTL_FETCH_GO]) && // see R21
          !(pwdata[CTL_PROGRAM_PERMIT] && pwdata[CTL_FETCH_PERMIT])) begin
        // Go with permit low does nothing
        prog_req = pwdata[CTL_PROGRAM_GO] && nvm_control.program_permit; // see R3
        fetch_req = pwdata[CTL_FETCH_GO] && nvm_control.fetch_permit;
      end else if (!(pwdata[CTL_PROGRAM_GO] && pwdata[CTL_FETCH_GO])) begin
        // Both permits high without both go bits: permits may land, go bits ignored
        prog_req = 1'b0;
        fetch_req = 1'b0;
      end else begin
        // Both go bits together: nothing starts
        prog_req = 1'b0;
        fetch_req = 1'b0;
      end
    end
  end

  // Completion conditions; a write ends on the tick edge that completes
  // the count, so that last tick stores the byte and releases the go bit
  // in one cycle.
  assign write_done = (state == ST_WRITE) && tick_rise && (cnt == WRITE_LAST); // see R4
  assign read_done = (state == ST_READ) && (cnt == READ_LAST); // see R23
  assign mem_wr = write_done;
  assign mem_rd = (state == ST_READ);

  // Timer tick arrives from its own oscillator, so it is synchronised
  // A tick level shorter than two system cycles may be missed entirely
  ebac_sync u_tick_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(write_timer_tick),
    .rise(tick_rise)
  ); // see R22

  // Array; its read port is registered, so a read needs two cycles at
  // least: one to load the array output, one to move it to the byte register
  ebac_mem #(
    .AW(LOC_W),
    .DW(BYTE_W)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .addr(op_addr),
    .wdata(op_data),
    .rdata(mem_rdata)
  );

  // Location register; upper bits are not stored at all
  // Bits above the index are dropped on write and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_location <= RST_LOCATION;
    end else if (ce && wr_acc && hit(paddr, OFF_LOCATION)) begin
      nvm_location <= pwdata[LOC_W-1:0]; // see R19
    end
  end

  // Byte register: software load, or the fetched byte at read end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_byte <= RST_BYTE;
    end else if (ce) begin
      if (read_done) begin
        // Fetched byte then stays until the next operation
        nvm_byte <= mem_rdata; // see R20
      end else if (wr_acc && hit(paddr, OFF_BYTE)) begin
        nvm_byte <= pwdata[7:0];
      end
    end
  end

  // Bank select starts at bank 0, hiding the control register
  // Any other bank value hides it too; only the exact pair opens the route
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select <= RST_BANK; // see R8
    end else if (ce && wr_acc && hit(paddr, OFF_BANK)) begin
      bank_select <= pwdata[7:0];
    end
  end

  // Indirect memory pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indirect_pointer_one <= RST_POINTER;
    end else if (ce && wr_acc && hit(paddr, OFF_POINTER)) begin
      indirect_pointer_one <= pwdata[7:0];
    end
  end

  // Permit bits: software owned, cleared at reset
  // They may change while busy; there is no abort, the engine runs on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_control.program_permit <= 1'b0; // see R7
      nvm_control.fetch_permit <= 1'b0;
    end else if (ce && wr_acc && hit(paddr, OFF_INDIRECT) && ctrl_open) begin
      nvm_control.program_permit <= pwdata[CTL_PROGRAM_PERMIT];
      nvm_control.fetch_permit <= pwdata[CTL_FETCH_PERMIT];
    end
  end

  // Go bits: software can only set them, hardware clears them; a zero
  // written while busy is ignored so polling always sees the real state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_control.program_go <= 1'b0;
      nvm_control.fetch_go <= 1'b0;
    end else if (ce) begin
      if (prog_req) begin
        nvm_control.program_go <= 1'b1;
      end else if (write_done) begin
        nvm_control.program_go <= 1'b0; // see R5
      end
      if (fetch_req) begin
        nvm_control.fetch_go <= 1'b1; // see R15
      end else if (read_done) begin
        nvm_control.fetch_go <= 1'b0; // see R16
      end
    end
  end

  // Sequencer state
  // A write has priority from idle, though both never start together
  // because such a request is refused in the start decode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (prog_req) begin
            state <= ST_WRITE;
          end else if (fetch_req) begin
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (read_done) begin
            state <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (write_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Counter: system cycles in a read, timer ticks in a write
  // In a write it moves only on synchronised tick edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (ce) begin
      if (state == ST_IDLE) begin
        cnt <= '0;
      end else if (state == ST_READ) begin
        cnt <= cnt + CNT_ONE;
      end else if (tick_rise) begin
        cnt <= cnt + CNT_ONE; // see R4
      end
    end
  end

  // Capture location and byte at start so later bus writes cannot
  // disturb an operation in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_addr <= RST_LOCATION;
      op_data <= RST_BYTE;
    end else if (ce && (prog_req || fetch_req)) begin
      op_addr <= nvm_location; // see R1
      op_data <= nvm_byte;
    end
  end

  // Interrupt enables: plain software bits
  // The flag bit of this word is handled by its own process below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ctrl.global_irq_enable <= 1'b0;
      irq_ctrl.nvm_irq_enable <= 1'b0;
    end else if (ce && wr_acc && hit(paddr, OFF_IRQ)) begin
      irq_ctrl.global_irq_enable <= pwdata[IRQ_GLOBAL_EN];
      irq_ctrl.nvm_irq_enable <= pwdata[IRQ_NVM_EN];
    end
  end

  // Request flag: set at write end, cleared on service or by a zero
  // written from software; a set in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ctrl.nvm_irq_flag <= 1'b0;
    end else if (ce) begin
      if (write_done) begin
        irq_ctrl.nvm_irq_flag <= 1'b1; // see R10
      end else if (irq_serviced) begin
        irq_ctrl.nvm_irq_flag <= 1'b0; // see R12
      end else if (wr_acc && hit(paddr, OFF_IRQ) && !pwdata[IRQ_NVM_FLAG]) begin
        irq_ctrl.nvm_irq_flag <= 1'b0;
      end
    end
  end

  // Vector request needs both enables and room on the return stack
  // Combinational, so the core sees the request in the same cycle
  assign irq_vector_req = irq_ctrl.nvm_irq_flag && irq_ctrl.global_irq_enable &&
                          irq_ctrl.nvm_irq_enable && !stack_full; // see R11

  // Read data is taken in the setup phase so it leaves a flip-flop;
  // the cost is that it reflects state one cycle before the access edge.
  // Unmapped addresses give an error and zero data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      pslverr <= !mapped;
      prdata <= '0;
      if (rd_setup) begin
        case (1'b1)
          hit(paddr, OFF_LOCATION): prdata <= word_of({2'b00, nvm_location}); // see R19
          hit(paddr, OFF_BYTE): prdata <= word_of(nvm_byte);
          hit(paddr, OFF_BANK): prdata <= word_of(bank_select);
          hit(paddr, OFF_POINTER): prdata <= word_of(indirect_pointer_one);
          hit(paddr, OFF_INDIRECT): begin
            // Control only when the pointer and bank select it
            if (ctrl_open) begin
              prdata <= word_of({4'h0, nvm_control}); // see R17
            end
          end
          hit(paddr, OFF_IRQ): prdata <= word_of({5'h00, irq_ctrl});
          default: prdata <= '0;
        endcase
      end
    end
  end

endmodule

// ### hdl/ebac_pkg.sv
// Contract
// R1: Firmware loads location and byte before writing
// R2: Permit set, then go in next instruction
// R3: Go without permit never starts a write
// R4: Write time comes from an independent timer
// R5: Hardware clears program go when write ends
// R6: Firmware polls go or takes the interrupt
// R7: Program permit is zero after reset
// R8: Bank select resets to zero, hiding control
// R9: Firmware sets the nvm interrupt enable first
// R10: Write end sets the nvm request flag
// R11: Vector needs both enables, stack not full
// R12: Servicing the interrupt clears the flag
// R13: Firmware masks interrupts around arming a write
// R14: No idle or sleep during an access
// R15: Fetch permit, then fetch go starts read
// R16: Hardware clears fetch go; firmware polls it
// R17: Control reached via pointer 40H, bank 01H
// R18: Firmware clears control and bank afterwards
// R19: Location holds six bits, upper read zero
// R20: Fetched byte stays until next operation
// R21: Never both go bits or all four
// R22: Write ticks counted on synchronised timer clock
// R23: Read completes in fixed system cycles
package ebac_pkg;

  // APB register byte addresses
  localparam logic [7:0] OFF_LOCATION = 8'h00;
  localparam logic [7:0] OFF_BYTE = 8'h04;
  localparam logic [7:0] OFF_BANK = 8'h08;
  localparam logic [7:0] OFF_POINTER = 8'h0C;
  localparam logic [7:0] OFF_INDIRECT = 8'h10;
  localparam logic [7:0] OFF_IRQ = 8'h14;

  // Indirect route to the control register
  localparam logic [7:0] CTRL_POINTER = 8'h40;
  localparam logic [7:0] CTRL_BANK = 8'h01;

  // Control field positions
  localparam int CTL_FETCH_GO = 0;
  localparam int CTL_FETCH_PERMIT = 1;
  localparam int CTL_PROGRAM_GO = 2;
  localparam int CTL_PROGRAM_PERMIT = 3;

  // Interrupt control field positions
  localparam int IRQ_GLOBAL_EN = 0;
  localparam int IRQ_NVM_EN = 1;
  localparam int IRQ_NVM_FLAG = 2;

  // Geometry and reset values
  localparam int LOC_W = 6;
  localparam int BYTE_W = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [LOC_W-1:0] RST_LOCATION = 6'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;

  // Default timing counts
  localparam int DEF_WRITE_TICKS = 8;
  localparam int DEF_READ_CYCLES = 2;

  // Control bits that travel together
  typedef struct packed {
    logic program_permit;
    logic program_go;
    logic fetch_permit;
    logic fetch_go;
  } ebac_ctrl_s;

  // Interrupt control bits
  typedef struct packed {
    logic nvm_irq_flag;
    logic nvm_irq_enable;
    logic global_irq_enable;
  } ebac_irq_s;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } ebac_state_e;

endpackage

// ### hdl/ebac_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
module ebac_sync
  import ebac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic async_in,
  output logic rise
);

  logic s1; // Metastability catcher, read only by s2
  logic s2;
  logic s3;
  logic level; // Filtered level

  // Shift chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once s2 and s3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else if (ce) begin
      rise <= (s2 == s3) && s3 && !level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule

// ### hdl/ebac_mem.sv
// Byte array with registered read data
module ebac_mem
  import ebac_pkg::*;
#(
  parameter int AW = LOC_W,
  parameter int DW = BYTE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] cells [0:(1<<AW)-1]; // Storage, no reset like real cells

  // Write port
  always_ff @(posedge pclk) begin
    if (ce && wr_en) begin
      cells[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (ce && rd_en) begin
      rdata <= cells[addr];
    end
  end

endmodule

// ### verif/ebac_props.sv
// Port-level checker for the nvm access controller
module ebac_props
  import ebac_pkg::*;
#(
  parameter int WRITE_TICKS = DEF_WRITE_TICKS,
  parameter int READ_CYCLES = DEF_READ_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stack_full,
  input wire logic irq_serviced,
  input wire logic irq_vector_req,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // Generous bound: a stalled timer would otherwise hang silently
  localparam int MAXW = 400;
  // Address decodes to one of the six words
  logic mapped;
  assign mapped = paddr inside {OFF_LOCATION, OFF_BYTE, OFF_BANK,
                                OFF_POINTER, OFF_INDIRECT, OFF_IRQ};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  err_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  start_src_a: assert property ($rose(busy) |->
    $past(psel && penable && pwrite && paddr == OFF_INDIRECT))
    else $error("busy rose without a control write");
  busy_min_a: assert property ($rose(busy) |=> busy)
    else $error("access ended at once");
  busy_end_a: assert property ($rose(busy) |-> ##[1:MAXW] !busy)
    else $error("access never ended");
  vec_stack_a: assert property (irq_vector_req |-> !stack_full)
    else $error("vector requested with full stack");
  serve_clr_a: assert property ($past(irq_serviced) && !$past(busy) |-> !irq_vector_req)
    else $error("vector stayed after service");
  loc_high_a: assert property (psel && penable && !pwrite && paddr == OFF_LOCATION
    |-> prdata[31:LOC_W] == '0)
    else $error("location upper bits not zero");
  ctl_high_a: assert property (psel && penable && !pwrite && paddr == OFF_INDIRECT
    |-> prdata[31:4] == '0)
    else $error("control upper bits not zero");
endmodule

bind ebac_ctrl ebac_props #(.WRITE_TICKS(WRITE_TICKS), .READ_CYCLES(READ_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stack_full(stack_full), .irq_serviced(irq_serviced),
  .irq_vector_req(irq_vector_req), .busy(busy)
);

// ### verif/ebac_core.sv
// Core model: APB master plus the firmware access sequences
module ebac_core
  import ebac_pkg::*;
(
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rd; // Scratch read data
  logic err; // Scratch error flag
  // Bus idles deselected
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control register reached only through the indirect port
  task automatic ctl(input logic [31:0] v);
    apb(1'b1, OFF_INDIRECT, v, rd, err);
  endtask
  // Pointer then bank select open the indirect route
  task automatic route();
    apb(1'b1, OFF_POINTER, {24'h0, CTRL_POINTER}, rd, err);
    apb(1'b1, OFF_BANK, {24'h0, CTRL_BANK}, rd, err);
  endtask
  // Write: operands first, masked arming, permit then go back to back
  task automatic prog(input logic [31:0] loc, input logic [31:0] b);
    apb(1'b1, OFF_LOCATION, loc, rd, err);
    apb(1'b1, OFF_BYTE, b, rd, err);
    route();
    apb(1'b1, OFF_IRQ, 32'h2, rd, err);
    ctl(32'h8);
    ctl(32'hC);
    apb(1'b1, OFF_IRQ, 32'h3, rd, err);
  endtask
  // Read: fetch permit then fetch go
  task automatic fetch(input logic [31:0] loc);
    apb(1'b1, OFF_LOCATION, loc, rd, err);
    route();
    ctl(32'h2);
    ctl(32'h3);
  endtask
  // Poll a go bit until it clears, bounded
  task automatic poll(input int bitn, output logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_INDIRECT, 32'h0, v, err);
      n++;
    end while (v[bitn] !== 1'b0 && n < 100);
  endtask
  // Drop both permits, then hide the control register again
  task automatic done();
    ctl(32'h0);
    apb(1'b1, OFF_BANK, 32'h0, rd, err);
  endtask
  // Byte lanes for the following transfers, changed between transfers
  task automatic lanes(input logic [3:0] s);
    pstrb <= s;
  endtask
endmodule

// ### verif/ebac_ctrl_tb.sv
// Self-checking bench for the nvm access controller
module ebac_ctrl_tb
  import ebac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic tick = 1'b0; // Free-running independent write timer
  logic ce = 1'b1; // Clock enable, dropped once to show the freeze
  logic stack_full = 1'b0;
  logic irq_serviced = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq_vector_req, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic err;
  int mismatches = 0;
  int check_count = 0;
  // Register access rows: write, address, data, expected read, expected error
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic er;
  } ebac_row_s;
  ebac_row_s rows [12] = '{
    '{1'b0, OFF_BANK, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_LOCATION, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_BYTE, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_IRQ, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_INDIRECT, 32'hA, 32'h0, 1'b0}, '{1'b1, OFF_POINTER, 32'h40, 32'h0, 1'b0},
    '{1'b1, OFF_BANK, 32'h1, 32'h0, 1'b0}, '{1'b0, OFF_INDIRECT, 32'h0, 32'h0, 1'b0},
    '{1'b1, OFF_LOCATION, 32'hFF, 32'h0, 1'b0}, '{1'b0, OFF_LOCATION, 32'h0, 32'h3F, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1}, '{1'b0, OFF_POINTER, 32'h0, 32'h40, 1'b0}
  };
  // Clock at 200 MHz; timer with unrelated phase
  always #2.5 pclk = ~pclk;
  always #37 tick = ~tick;
  ebac_core core (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));
  // Short write so the run stays brief
  ebac_ctrl #(.WRITE_TICKS(2), .READ_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_timer_tick(tick), .stack_full(stack_full), .irq_serviced(irq_serviced),
    .irq_vector_req(irq_vector_req), .busy(busy));
  // Compare with case equality so unknowns never match
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      core.apb(rows[i].wr, rows[i].a, rows[i].d, rd, err);
      if (!rows[i].wr) check("row read", rd, rows[i].e);
      check("row error", {31'h0, err}, {31'h0, rows[i].er});
    end
    // Go without permit starts nothing
    core.ctl(32'h4);
    core.apb(1'b0, OFF_INDIRECT, 32'h0, rd, err);
    check("go no permit", rd, 32'h0);
    check("busy no permit", {31'h0, busy}, 32'h0);
    // Full write with interrupt
    core.prog(32'h05, 32'h3C);
    core.apb(1'b0, OFF_INDIRECT, 32'h0, rd, err);
    check("write running", rd, 32'hC);
    check("busy write", {31'h0, busy}, 32'h1);
    core.poll(CTL_PROGRAM_GO, rd);
    check("write done", rd, 32'h8);
    core.apb(1'b0, OFF_IRQ, 32'h0, rd, err);
    check("flag set", rd, 32'h7);
    #1 check("vector on", {31'h0, irq_vector_req}, 32'h1);
    core.apb(1'b1, OFF_IRQ, 32'h6, rd, err);
    #1 check("vector global off", {31'h0, irq_vector_req}, 32'h0);
    core.apb(1'b1, OFF_IRQ, 32'h7, rd, err);
    stack_full <= 1'b1;
    @(posedge pclk);
    #1 check("vector stack full", {31'h0, irq_vector_req}, 32'h0);
    @(posedge pclk);
    stack_full <= 1'b0;
    irq_serviced <= 1'b1;
    @(posedge pclk);
    irq_serviced <= 1'b0;
    core.apb(1'b0, OFF_IRQ, 32'h0, rd, err);
    check("flag cleared", rd, 32'h3);
    core.done();
    // Read back the stored byte after clobbering the byte register
    core.apb(1'b1, OFF_BYTE, 32'h0, rd, err);
    core.fetch(32'h05);
    core.poll(CTL_FETCH_GO, rd);
    check("fetch done", rd, 32'h2);
    core.apb(1'b0, OFF_BYTE, 32'h0, rd, err);
    check("fetched byte", rd, 32'h3C);
    repeat (20) @(posedge pclk);
    core.apb(1'b0, OFF_BYTE, 32'h0, rd, err);
    check("byte kept", rd, 32'h3C);
    // Frozen engine while idle: a write in that time is lost
    ce <= 1'b0;
    core.apb(1'b1, OFF_BYTE, 32'h55, rd, err);
    ce <= 1'b1;
    core.apb(1'b0, OFF_BYTE, 32'h0, rd, err);
    check("byte frozen", rd, 32'h3C);
    // A write with byte lane 0 off is ignored
    core.lanes(4'hE);
    core.apb(1'b1, OFF_BYTE, 32'h66, rd, err);
    core.lanes(4'hF);
    core.apb(1'b0, OFF_BYTE, 32'h0, rd, err);
    check("byte lane off", rd, 32'h3C);
    // All four bits at once: permits kept, nothing starts
    core.ctl(32'hF);
    #1 check("busy all four", {31'h0, busy}, 32'h0);
    core.apb(1'b0, OFF_INDIRECT, 32'h0, rd, err);
    check("all four", rd, 32'hA);
    core.done();
    tally_and_finish();
  end
endmodule
